// ==== cpu_exc_defines.svh ====
`ifndef CPU_EXC_DEFINES_SVH
`define CPU_EXC_DEFINES_SVH
`define IRQ_W 32
`define LVL_W 6
`define SYNC_W 35
`define CLK_PERIOD_NS 10
`define RST_ACK_PERIOD_NS 160
`define RST_ACK_CYCLES ((`RST_ACK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OFS_CTRL 8'h00
`define OFS_IENABLE 8'h04
`define OFS_IPENDING 8'h08
`define OFS_STATUS 8'h0C
`define OFS_EXC_ADDR 8'h10
`define OFS_BRK_ADDR 8'h14
`define OFS_RST_ADDR 8'h18
`define OFS_CUR_LEVEL 8'h1C
`define CTRL_GIE_BIT 0
`define CTRL_EIC_BIT 1
`define RST_CTRL 2'h0
`define RST_IENABLE 32'h00000000
`define RST_EXC_ADDR 32'h00000020
`define RST_BRK_ADDR 32'h00000040
`define RST_RST_ADDR 32'h00000000
`define RST_LEVEL 6'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== cpu_exc_pkg.sv ====
`include "cpu_exc_defines.svh"
package cpu_exc_pkg;
   typedef struct packed {
      logic awvalid;
      logic [31:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [31:0] araddr;
      logic rready;
   } axiReq_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axiRsp_t;
   typedef struct packed {
      logic valid;
      logic nmi;
      logic [5:0] level;
      logic [5:0] regSet;
      logic [31:0] handler;
   } eicIn_t;
   typedef enum logic [2:0] {
      S_BOOT, S_RUN, S_HS, S_DRAIN, S_RST, S_DBG, S_STEP
   } ctrlState_t;
endpackage

// ==== pin_sync.sv ====
`include "cpu_exc_defines.svh"
module pin_sync (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [`SYNC_W-1:0] pins,
   output logic [`SYNC_W-1:0] synced
);
   logic [`SYNC_W-1:0] s1_q;
   logic [`SYNC_W-1:0] s2_q;
   logic [`SYNC_W-1:0] s3_q;
   logic [`SYNC_W-1:0] diff;
   assign diff = s2_q ^ s3_q;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         synced <= '0;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // A change counts only once two stages agree
         synced <= (~diff & s3_q) | (diff & synced);
      end
   end
endmodule // pin_sync

// ==== ack_timer.sv ====
`include "cpu_exc_defines.svh"
module ack_timer (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic run,
   output logic tick
);
   localparam logic [7:0] LAST = 8'(`RST_ACK_CYCLES - 1);
   logic [7:0] cnt_q;
   always_ff @(posedge clk_sys) begin
      if (reset || !run) begin
         cnt_q <= 8'h00;
         tick <= 1'b0;
      end else if (cnt_q == LAST) begin
         cnt_q <= 8'h00;
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         tick <= 1'b0;
      end
   end
endmodule // ack_timer

// ==== cpu_exc_ctrl.sv ====
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`include "cpu_exc_defines.svh"
module cpu_exc_ctrl
   import cpu_exc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire axiReq_t axiReq,
   output axiRsp_t axiRsp,
   input wire logic [`IRQ_W-1:0] irqPin,
   input wire logic resetReqPin,
   input wire logic debugReqPin,
   input wire logic hsReqPin,
   input wire logic pipeEmpty,
   input wire logic boundary,
   input wire logic fault,
   input wire logic dbgResume,
   input wire logic dbgStep,
   input wire eicIn_t external_interrupt_controller,
   output logic resetTaken_q,
   output logic debugAck_q,
   output logic hsAck_q,
   output logic fetchStall_q,
   output logic inReset_q,
   output logic redirect_q,
   output logic [31:0] redirectAddr_q,
   output logic [5:0] regSet_q,
   output logic resetRead_q,
   output logic eicAck_q
);
   function automatic logic [31:0] mergeStrb(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic regHit(input logic [31:0] a);
      return (a[31:8] == 24'h000000) && (a[1:0] == 2'h0) &&
         (a[7:0] <= `OFS_CUR_LEVEL);
   endfunction

   ctrlState_t state_q;
   logic [`SYNC_W-1:0] syncd;
   logic [`IRQ_W-1:0] irqS;
   logic resetReqS;
   logic debugReqS;
   logic hsReqS;
   logic tick;
   logic gie_q;
   logic eicMode_q;
   logic [`IRQ_W-1:0] ienable_q;
   logic [31:0] excAddr_q;
   logic [31:0] brkAddr_q;
   logic [31:0] rstAddr_q;
   logic [5:0] curLevel_q;
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic awHave_q;
   logic wHave_q;
   logic [31:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic wrEn;
   logic [`IRQ_W-1:0] ipending;
   logic irqTake;
   logic eicTake;
   logic atBoundary;
   logic [31:0] rdMux;

   pin_sync u_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .pins({hsReqPin, debugReqPin, resetReqPin, irqPin}),
      .synced(syncd)
   );

   assign irqS = syncd[`IRQ_W-1:0];
   assign resetReqS = syncd[`IRQ_W];
   assign debugReqS = syncd[`IRQ_W+1];
   assign hsReqS = syncd[`IRQ_W+2];

   ack_timer u_timer (
      .clk_sys(clk_sys),
      .reset(reset),
      .run(state_q == S_RST),
      .tick(tick)
   );

   // Internal lines are dead in external controller mode
   assign ipending = eicMode_q ? '0 : (irqS & ienable_q);
   assign irqTake = gie_q && (|ipending);
   // Non-maskable requests bypass enable and level
   assign eicTake = eicMode_q && external_interrupt_controller.valid &&
      (external_interrupt_controller.nmi || (gie_q && (external_interrupt_controller.level > curLevel_q)));
   // Boundary decisions are made only when no reset flow is pending
   assign atBoundary = (state_q == S_RUN) && boundary && !hsReqS &&
      !resetReqS;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= S_BOOT;
         fetchStall_q <= 1'b1;
         inReset_q <= 1'b1;
         debugAck_q <= 1'b0;
         hsAck_q <= 1'b0;
         redirect_q <= 1'b0;
         redirectAddr_q <= 32'h00000000;
         regSet_q <= 6'h00;
         eicAck_q <= 1'b0;
      end else begin
         redirect_q <= 1'b0;
         eicAck_q <= 1'b0;
         case (state_q)
            S_BOOT: begin
               inReset_q <= 1'b0;
               fetchStall_q <= 1'b0;
               redirect_q <= 1'b1;
               redirectAddr_q <= rstAddr_q;
               regSet_q <= 6'h00;
               state_q <= S_RUN;
            end
            S_RUN: begin
               if (hsReqS) begin
                  fetchStall_q <= 1'b1;
                  state_q <= S_HS;
               end else if (resetReqS) begin
                  fetchStall_q <= 1'b1;
                  state_q <= S_DRAIN;
               end else if (boundary && debugReqS) begin
                  fetchStall_q <= 1'b1;
                  debugAck_q <= 1'b1;
                  redirect_q <= 1'b1;
                  redirectAddr_q <= brkAddr_q;
                  state_q <= S_DBG;
               end else if (boundary && fault) begin
                  // Redirect and flush at the faulting boundary keeps order
                  redirect_q <= 1'b1;
                  redirectAddr_q <= excAddr_q;
               end else if (boundary && eicTake) begin
                  redirect_q <= 1'b1;
                  eicAck_q <= 1'b1;
                  redirectAddr_q <= external_interrupt_controller.handler;
                  regSet_q <= external_interrupt_controller.regSet;
               end else if (boundary && irqTake) begin
                  redirect_q <= 1'b1;
                  redirectAddr_q <= excAddr_q;
               end
            end
            S_HS: begin
               if (pipeEmpty) begin
                  hsAck_q <= 1'b1;
                  inReset_q <= 1'b1;
                  state_q <= S_RST;
               end
            end
            S_DRAIN: begin
               if (pipeEmpty) begin
                  inReset_q <= 1'b1;
                  state_q <= S_RST;
               end
            end
            S_RST: begin
               if (!resetReqS && !hsReqS) begin
                  hsAck_q <= 1'b0;
                  state_q <= S_BOOT;
               end
            end
            S_DBG: begin
               // Reset and halt requests are not looked at while paused
               if (dbgResume || dbgStep) begin
                  debugAck_q <= 1'b0;
                  if (resetReqS) begin
                     state_q <= S_DRAIN;
                  end else if (dbgStep) begin
                     fetchStall_q <= 1'b0;
                     state_q <= S_STEP;
                  end else begin
                     fetchStall_q <= 1'b0;
                     state_q <= S_RUN;
                  end
               end
            end
            S_STEP: begin
               if (resetReqS) begin
                  fetchStall_q <= 1'b1;
                  state_q <= S_DRAIN;
               end else if (boundary) begin
                  fetchStall_q <= 1'b1;
                  debugAck_q <= 1'b1;
                  state_q <= S_DBG;
               end
            end
            default: begin
               state_q <= S_BOOT;
            end
         endcase
      end
   end

   // Acknowledge on entry and on every timer tick in reset
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         resetTaken_q <= 1'b0;
         resetRead_q <= 1'b0;
      end else begin
         resetTaken_q <= ((state_q == S_DRAIN || state_q == S_HS) &&
            pipeEmpty) || (state_q == S_RST && tick);
         // Dummy fetch from the reset address, data is dropped
         resetRead_q <= (state_q == S_RST) && tick;
      end
   end

   // Hardware clears the global enable on entry; software re-enables
   // to allow nesting in whatever order it chooses
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         gie_q <= 1'(`RST_CTRL >> `CTRL_GIE_BIT);
         eicMode_q <= 1'b0;
         ienable_q <= `RST_IENABLE;
         excAddr_q <= `RST_EXC_ADDR;
         brkAddr_q <= `RST_BRK_ADDR;
         rstAddr_q <= `RST_RST_ADDR;
         curLevel_q <= `RST_LEVEL;
      end else begin
         if (wrEn && awAddr_q[7:0] == `OFS_CTRL && wStrb_q[0]) begin
            gie_q <= wData_q[`CTRL_GIE_BIT];
            eicMode_q <= wData_q[`CTRL_EIC_BIT];
         end
         if (wrEn && awAddr_q[7:0] == `OFS_IENABLE) begin
            ienable_q <= mergeStrb(ienable_q, wData_q, wStrb_q);
         end
         if (wrEn && awAddr_q[7:0] == `OFS_EXC_ADDR) begin
            excAddr_q <= mergeStrb(excAddr_q, wData_q, wStrb_q);
         end
         if (wrEn && awAddr_q[7:0] == `OFS_BRK_ADDR) begin
            brkAddr_q <= mergeStrb(brkAddr_q, wData_q, wStrb_q);
         end
         if (wrEn && awAddr_q[7:0] == `OFS_RST_ADDR) begin
            rstAddr_q <= mergeStrb(rstAddr_q, wData_q, wStrb_q);
         end
         if (wrEn && awAddr_q[7:0] == `OFS_CUR_LEVEL && wStrb_q[0]) begin
            curLevel_q <= wData_q[5:0];
         end
         if (atBoundary && !debugReqS && (fault || eicTake || irqTake)) begin
            gie_q <= 1'b0;
            if (!fault && eicTake && !external_interrupt_controller.nmi) begin
               curLevel_q <= external_interrupt_controller.level;
            end
         end
      end
   end

   // Write channel: address and data in either order
   assign wrEn = awHave_q && wHave_q && !bvalid_q;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
         awAddr_q <= 32'h00000000;
         wData_q <= 32'h00000000;
         wStrb_q <= 4'h0;
      end else begin
         if (axiReq.awvalid && awready_q) begin
            awAddr_q <= axiReq.awaddr;
            awHave_q <= 1'b1;
            awready_q <= 1'b0;
         end
         if (axiReq.wvalid && wready_q) begin
            wData_q <= axiReq.wdata;
            wStrb_q <= axiReq.wstrb;
            wHave_q <= 1'b1;
            wready_q <= 1'b0;
         end
         if (wrEn) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= regHit(awAddr_q) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid_q && axiReq.bready) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   always_comb begin
      case (axiReq.araddr[7:0])
         `OFS_CTRL: rdMux = {30'h0, eicMode_q, gie_q};
         `OFS_IENABLE: rdMux = ienable_q;
         `OFS_IPENDING: rdMux = ipending;
         `OFS_STATUS: rdMux = {26'h0, inReset_q, debugAck_q, hsAck_q,
            fetchStall_q, resetReqS, debugReqS};
         `OFS_EXC_ADDR: rdMux = excAddr_q;
         `OFS_BRK_ADDR: rdMux = brkAddr_q;
         `OFS_RST_ADDR: rdMux = rstAddr_q;
         `OFS_CUR_LEVEL: rdMux = {26'h0, curLevel_q};
         default: rdMux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `RESP_OKAY;
      end else if (axiReq.arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= regHit(axiReq.araddr) ? rdMux : 32'h00000000;
         rresp_q <= regHit(axiReq.araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_q && axiReq.rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   assign axiRsp = '{awready: awready_q, wready: wready_q,
      bvalid: bvalid_q, bresp: bresp_q, arready: arready_q,
      rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   // Cycles in reset since the last acknowledge, for the period check
   logic [7:0] sinceAck_q;
   always_ff @(posedge clk_sys) begin
      if (reset || state_q != S_RST || resetTaken_q) begin
         sinceAck_q <= 8'h00;
      end else begin
         sinceAck_q <= sinceAck_q + 8'h01;
      end
   end

   sequence dbgEnter;
      atBoundary && debugReqS ##1 state_q == S_DBG && redirect_q;
   endsequence

   sequence drainThenReset;
      state_q == S_DRAIN && pipeEmpty ##1 state_q == S_RST && resetTaken_q;
   endsequence

   global_reset_a: assert property (disable iff (1'b0)
      reset |=> state_q == S_BOOT && !resetTaken_q && !debugAck_q)
      else $error("global reset did not clear control at once");
   drain_wait_a: assert property (state_q == S_DRAIN && !pipeEmpty
      |=> state_q != S_RST)
      else $error("reset entered before pipeline drained");
   drain_ack_a: assert property (state_q == S_DRAIN && pipeEmpty
      |-> drainThenReset)
      else $error("no acknowledge on local reset entry");
   ack_pulse_a: assert property (resetTaken_q |=> !resetTaken_q)
      else $error("reset acknowledge wider than one cycle");
   ack_repeat_a: assert property (state_q == S_RST
      |-> sinceAck_q <= 8'(`RST_ACK_CYCLES))
      else $error("acknowledge not repeated while held");
   rst_hold_a: assert property (state_q == S_RST && resetReqS
      |=> state_q == S_RST && inReset_q && !redirect_q)
      else $error("left reset while request held");
   read_tick_a: assert property (resetRead_q |-> $past(state_q) == S_RST
      && resetTaken_q)
      else $error("reset address read outside reset");
   dbg_ignore_a: assert property (state_q == S_DBG && !dbgResume &&
      !dbgStep |=> state_q == S_DBG && debugAck_q && !redirect_q)
      else $error("paused core reacted to a request");
   dbg_release_a: assert property ((state_q == S_DBG ||
      state_q == S_STEP) && resetReqS && (dbgResume || dbgStep ||
      state_q == S_STEP) |=> state_q == S_DRAIN)
      else $error("pending reset not honoured at release");
   dbg_entry_a: assert property (atBoundary && debugReqS |-> dbgEnter)
      else $error("debug halt did not pause");
   dbg_addr_a: assert property (atBoundary && debugReqS
      |=> debugAck_q && redirectAddr_q == $past(brkAddr_q))
      else $error("debug halt not sent to break address");
   hs_ack_a: assert property (state_q == S_HS && !pipeEmpty
      |=> !hsAck_q && !inReset_q)
      else $error("handshake answered before drain");
   exc_addr_a: assert property (atBoundary && !debugReqS && fault
      |=> redirect_q && redirectAddr_q == $past(excAddr_q))
      else $error("exception not sent to exception address");
   irq_gate_a: assert property (atBoundary && !debugReqS && !fault &&
      !gie_q && !eicMode_q |=> !redirect_q)
      else $error("interrupt taken with global enable clear");
   irq_take_a: assert property (atBoundary && !debugReqS && !fault &&
      !eicMode_q && gie_q && (|(irqS & ienable_q))
      |=> redirect_q && redirectAddr_q == $past(excAddr_q))
      else $error("enabled interrupt not taken");
   eic_only_a: assert property (eicMode_q |-> ipending == '0)
      else $error("internal lines live in external mode");
   eic_level_a: assert property (atBoundary && !debugReqS && !fault &&
      eicMode_q && external_interrupt_controller.valid && !external_interrupt_controller.nmi && external_interrupt_controller.level <= curLevel_q
      |=> !redirect_q)
      else $error("external interrupt taken at too low level");
   nmi_take_a: assert property (atBoundary && !debugReqS && !fault &&
      eicMode_q && external_interrupt_controller.valid && external_interrupt_controller.nmi
      |=> redirect_q && eicAck_q && redirectAddr_q == $past(external_interrupt_controller.handler))
      else $error("non-maskable interrupt not taken");
endmodule // cpu_exc_ctrl

// ==== cpu_sys_model.sv ====
module cpu_sys_model
   import cpu_exc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic rstCmd,
   input wire logic hsCmd,
   input wire logic eicHold,
   input wire eicIn_t eicCmd,
   input wire logic resetTaken_q,
   input wire logic hsAck_q,
   input wire logic eicAck_q,
   output logic resetReqPin,
   output logic hsReqPin,
   output eicIn_t external_interrupt_controller
);
   timeunit 1ns;
   timeprecision 1ps;
   logic acked_q;
   logic hold_q;
   // Requests may not drop before the core answers, even if asked to
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         resetReqPin <= 1'h0;
         acked_q <= 1'h0;
         hsReqPin <= 1'h0;
      end else begin
         acked_q <= resetReqPin & (acked_q | resetTaken_q);
         resetReqPin <= rstCmd |
            (resetReqPin & ~acked_q & ~resetTaken_q);
         hsReqPin <= hsCmd | (hsReqPin & ~hsAck_q);
      end
   end
   // A withdrawn offer scrambles its payload so nothing stale looks valid
   always_ff @(posedge clk_sys) begin
      hold_q <= eicHold & ~reset;
      if (reset) begin
         external_interrupt_controller <= '0;
      end else if (eicAck_q || !eicHold) begin
         external_interrupt_controller <= {1'h0, ~external_interrupt_controller[$bits(eicIn_t)-2:0]};
      end else if (!hold_q) begin
         external_interrupt_controller <= eicCmd;
      end
   end
endmodule // cpu_sys_model

// ==== cpu_reset_debug_interrupt_ctrl_tb.sv ====
`include "cpu_exc_defines.svh"
module cpu_reset_debug_interrupt_ctrl_tb
   import cpu_exc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic wr;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] q;
      logic [1:0] r;
   } row_t;
   typedef struct packed {
      logic [1:0] ctrl;
      logic nmi;
      logic [5:0] lvl;
      logic want;
   } eicRow_t;
   localparam logic [1:0] OK = `RESP_OKAY;
   localparam logic [1:0] ER = `RESP_SLVERR;
   row_t rows[] = '{
      '{1'h0, `OFS_CTRL, 32'h0, `RST_CTRL, OK},
      '{1'h0, `OFS_IENABLE, 32'h0, `RST_IENABLE, OK},
      '{1'h0, `OFS_EXC_ADDR, 32'h0, `RST_EXC_ADDR, OK},
      '{1'h0, `OFS_BRK_ADDR, 32'h0, `RST_BRK_ADDR, OK},
      '{1'h0, `OFS_RST_ADDR, 32'h0, `RST_RST_ADDR, OK},
      '{1'h0, `OFS_CUR_LEVEL, 32'h0, `RST_LEVEL, OK},
      '{1'h1, `OFS_IENABLE, 32'hA5A5_5A5A, 32'h0, OK},
      '{1'h0, `OFS_IENABLE, 32'h0, 32'hA5A5_5A5A, OK},
      '{1'h1, `OFS_STATUS, 32'hFFFF_FFFF, 32'h0, OK},
      '{1'h0, `OFS_STATUS, 32'h0, 32'h0, OK},
      '{1'h1, `OFS_EXC_ADDR, 32'h100, 32'h0, OK},
      '{1'h1, `OFS_BRK_ADDR, 32'h200, 32'h0, OK},
      '{1'h1, `OFS_RST_ADDR, 32'h400, 32'h0, OK},
      '{1'h0, `OFS_EXC_ADDR, 32'h0, 32'h100, OK},
      '{1'h1, 8'h20, 32'h1, 32'h0, ER},
      '{1'h0, 8'h20, 32'h0, 32'h0, ER},
      '{1'h0, 8'h06, 32'h0, 32'h0, ER}
   };
   // Second offer sits at the current level, so it must wait
   eicRow_t er[3] = '{'{2'h3, 1'h0, 6'h05, 1'h1},
      '{2'h3, 1'h0, 6'h05, 1'h0}, '{2'h2, 1'h1, 6'h00, 1'h1}};
   logic clk_sys = 1'h0;
   logic reset = 1'h1;
   axiReq_t req = '0;
   axiRsp_t rsp;
   logic [31:0] irqPin = '0;
   logic debugReqPin = 1'h0, pipeEmpty = 1'h1, fault = 1'h0;
   logic dbgResume = 1'h0, rstCmd = 1'h0, hsCmd = 1'h0, eicHold = 1'h0;
   logic dbgStep = 1'h0;
   eicIn_t eicCmd = '0, external_interrupt_controller;
   logic resetReqPin, hsReqPin, resetTaken_q, debugAck_q, hsAck_q;
   logic fetchStall_q, inReset_q, resetRead_q, eicAck_q, redirect_q;
   logic [31:0] redirectAddr_q, q;
   logic [5:0] regSet_q;
   logic [1:0] r;
   logic hitRead;
   int mismatches = 0, total_checks = 0, c;
   always #5 clk_sys = ~clk_sys;
   cpu_exc_ctrl cpu_exc_ctrl_inst (.clk_sys, .reset, .axiReq(req),
      .axiRsp(rsp), .irqPin, .resetReqPin, .debugReqPin, .hsReqPin,
      .pipeEmpty, .boundary(1'h1), .fault, .dbgResume, .dbgStep,
      .external_interrupt_controller, .resetTaken_q, .debugAck_q, .hsAck_q, .fetchStall_q,
      .inReset_q, .redirect_q, .redirectAddr_q, .regSet_q, .resetRead_q,
      .eicAck_q);
   cpu_sys_model cpu_sys_model_inst (.clk_sys, .reset, .rstCmd, .hsCmd,
      .eicHold, .eicCmd, .resetTaken_q, .hsAck_q, .eicAck_q, .resetReqPin,
      .hsReqPin, .external_interrupt_controller);
   task automatic chk(input logic [31:0] got, exp, input string m);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic print_verdict();
      if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic axi(input logic wr, input logic [31:0] a, dat,
         output logic [31:0] rd, output logic [1:0] rs);
      @(posedge clk_sys);
      req.awvalid <= wr;
      req.wvalid <= wr;
      req.bready <= wr;
      req.arvalid <= !wr;
      req.rready <= !wr;
      req.awaddr <= a;
      req.araddr <= a;
      req.wdata <= dat;
      req.wstrb <= 4'hF;
      do begin
         @(posedge clk_sys);
         if (rsp.awready) req.awvalid <= 1'h0;
         if (rsp.wready) req.wvalid <= 1'h0;
         if (rsp.arready) req.arvalid <= 1'h0;
      end while (!(wr ? rsp.bvalid : rsp.rvalid));
      rd = rsp.rdata;
      rs = wr ? rsp.bresp : rsp.rresp;
      req.bready <= 1'h0;
      req.rready <= 1'h0;
   endtask
   // Edges until the chosen pulse shows; lim + 1 when it never does
   task automatic waitEv(input int s, lim, output int n);
      logic hit;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
         hit = s == 0 ? redirect_q : s == 1 ? resetTaken_q : eicAck_q;
      end while (!hit && n < lim);
      hitRead = resetRead_q;
      if (hit !== 1'h1) n = lim + 1;
   endtask
   initial begin
      #100000;
      mismatches++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      reset <= 1'h0;
      foreach (rows[i]) begin
         axi(rows[i].wr, {24'h0, rows[i].a}, rows[i].d, q, r);
         chk(r, rows[i].r, "response");
         if (!rows[i].wr) chk(q, rows[i].q, "read data");
      end
      for (int n = 0; n < 32; n += 31) begin
         axi(1'h1, `OFS_IENABLE, 32'h1 << n, q, r);
         axi(1'h1, `OFS_CTRL, 32'h1, q, r);
         irqPin <= ~(32'h1 << n);
         waitEv(0, 12, c);
         chk(c, 13, "masked lines");
         irqPin <= 32'h1 << n;
         waitEv(0, 12, c);
         chk(redirectAddr_q, 32'h100, "irq vector");
         irqPin <= '0;
         axi(1'h0, `OFS_CTRL, 32'h0, q, r);
         chk(q[0], 1'h0, "enable cleared on entry");
      end
      fault <= 1'h1;
      @(posedge clk_sys);
      fault <= 1'h0;
      waitEv(0, 3, c);
      chk(c, 1, "fault at its boundary");
      chk(redirectAddr_q, 32'h100, "fault vector");
      debugReqPin <= 1'h1;
      waitEv(0, 12, c);
      chk(redirectAddr_q, 32'h200, "break vector");
      chk(debugAck_q, 1'h1, "halt ack");
      debugReqPin <= 1'h0;
      rstCmd <= 1'h1;
      pipeEmpty <= 1'h0;
      waitEv(1, 12, c);
      chk(c, 13, "reset while paused");
      debugReqPin <= 1'h1;
      waitEv(0, 12, c);
      chk(c, 13, "halt while paused");
      debugReqPin <= 1'h0;
      dbgResume <= 1'h1;
      @(posedge clk_sys);
      dbgResume <= 1'h0;
      waitEv(1, 10, c);
      chk(c, 11, "drain first");
      chk(fetchStall_q, 1'h1, "no issue in drain");
      pipeEmpty <= 1'h1;
      waitEv(1, 4, c);
      chk(inReset_q, 1'h1, "reset on resume");
      waitEv(1, 40, c);
      waitEv(1, 40, c);
      chk(c, `RST_ACK_CYCLES, "ack period");
      chk(hitRead & inReset_q, 1'h1, "reset read");
      rstCmd <= 1'h0;
      waitEv(0, 20, c);
      chk(redirectAddr_q, 32'h400, "restart vector");
      pipeEmpty <= 1'h0;
      hsCmd <= 1'h1;
      repeat (10) @(posedge clk_sys);
      chk(hsAck_q, 1'h0, "handshake waits");
      pipeEmpty <= 1'h1;
      repeat (3) @(posedge clk_sys);
      chk(hsAck_q & inReset_q, 1'h1, "handshake done");
      hsCmd <= 1'h0;
      waitEv(0, 20, c);
      chk(redirectAddr_q, 32'h400, "restart after handshake");
      irqPin <= 32'h8000_0000;
      foreach (er[i]) begin
         axi(1'h1, `OFS_CTRL, {30'h0, er[i].ctrl}, q, r);
         eicCmd <= '{1'h1, er[i].nmi, er[i].lvl, 6'h02, 32'h300};
         eicHold <= 1'h1;
         waitEv(0, 8, c);
         chk(c <= 8, er[i].want, "offer taken");
         if (er[i].want) chk(redirectAddr_q, 32'h300, "handler");
         eicHold <= 1'h0;
      end
      axi(1'h0, `OFS_CUR_LEVEL, 32'h0, q, r);
      chk(q, 32'h5, "level kept over nmi");
      chk(regSet_q, 6'h02, "register set");
      debugReqPin <= 1'h1;
      waitEv(0, 12, c);
      debugReqPin <= 1'h0;
      dbgStep <= 1'h1;
      @(posedge clk_sys);
      dbgStep <= 1'h0;
      repeat (2) @(posedge clk_sys);
      chk(debugAck_q, 1'h1, "step pauses again");
      rstCmd <= 1'h1;
      repeat (8) @(posedge clk_sys);
      chk(inReset_q, 1'h0, "reset ignored in pause");
      dbgStep <= 1'h1;
      @(posedge clk_sys);
      dbgStep <= 1'h0;
      waitEv(1, 4, c);
      chk(c <= 4, 1'h1, "reset on step release");
      pipeEmpty <= 1'h0;
      rstCmd <= 1'h1;
      repeat (8) @(posedge clk_sys);
      reset <= 1'h1;
      @(posedge clk_sys);
      reset <= 1'h0;
      rstCmd <= 1'h0;
      @(posedge clk_sys);
      chk(inReset_q, 1'h1, "immediate reset");
      waitEv(0, 3, c);
      chk(c, 1, "boot redirect");
      chk(redirectAddr_q, `RST_RST_ADDR, "boot vector");
      print_verdict();
   end
endmodule // cpu_reset_debug_interrupt_ctrl_tb
